// *** rtl/ods_pkg.sv ***
// Shared constants and types for the oscillator divider and enabling sequencer
package ods_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    // Master clock cycles to let the reference settle after a power-up
    localparam int STAB_MCLK_CYCLES = 256;
    localparam logic [8:0] STAB_LAST = 9'(STAB_MCLK_CYCLES - 1);

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_DIV = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [8:0] MODE_RESET = 9'h034;
    localparam logic [8:0] DIV_RESET = 9'h000;
    // The three top mode bits must stay zero
    localparam logic [8:0] MODE_WRITE_MASK = 9'h03F;
    localparam logic [8:0] DIVISOR_OFFSET = 9'h002;
    // Synchronisers start at the idle pin levels {enable, shared pin, external}
    // so that a released reset cannot fake a power-down request
    localparam logic [2:0] SYNC_RESET = 3'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [2:0] zero;
        logic refOutDisable;
        logic pdSelect;
        logic prescaleHalf;
        logic prescaleBypass;
        logic dividerBypass;
        logic extSelect;
    } ods_mode_t;

    // Gray coded along INT -> HOLD_EXT -> EXT -> HOLD_INT -> INT
    typedef enum logic [1:0] {
        SW_INT = 2'b00,
        SW_HOLD_EXT = 2'b01,
        SW_EXT = 2'b11,
        SW_HOLD_INT = 2'b10
    } ods_sw_state_t;

    // Gray coded along RUN -> OUT_OFF -> REF_OFF -> WAKE -> RUN
    typedef enum logic [1:0] {
        PD_RUN = 2'b00,
        PD_OUT_OFF = 2'b01,
        PD_REF_OFF = 2'b11,
        PD_WAKE = 2'b10
    } ods_pd_state_t;

    typedef struct packed {
        logic [23:0] zero;
        logic usingExt;
        logic oeSampled;
        logic divGate;
        logic divOut;
        ods_pd_state_t pdState;
        ods_sw_state_t swState;
    } ods_status_t;
endpackage

// *** rtl/ods_osc_divider.sv ***
// Oscillator prescaler, reference switch, programmable divider and enabling sequencer
//
// How it works
// - Power-down-select bit 0: shared pin picks reference; bit 1: pin powers down.
// - Reference-output-disable 1 floats reference output; 0 drives master clock.
// - Output-enable never touches reference output; power-down still disables it.
// - Divider divides by the nine-bit value plus two, range 2 to 513.
// - Output-enable sampled on master clock rise, gating the divider output.
// - Gating never shortens a high output pulse.
// - Enable change missing the sample edge completes one master cycle later.
// - First divided rise follows output-enable by one to two master periods.
// - Disable during a high pulse lets it finish, then holds low.
// - Disable while low but past the sample edge lets one more pulse out.
// - Divide-by-one disable passes one extra pulse, two when sampled late.
// - Select mode switches internal and external reference without glitches.
// - Divided output follows the switched reference at its divided rate.
// - Falling select requests external, detected on falling internal edge.
// - Hold low at least half internal period, route external once low.
// - Return to internal is level triggered on a low external clock.
// - Select high, external low: hold low to internal fall, pass next rise.
// - Output-enable low keeps oscillator running and clears divider counter.
// - Prescale bit 0 divides by 4, 1 by 2, unless prescaler or divider bypassed.
`timescale 1ns/100ps
module ods_osc_divider (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic outputEnable,
    input wire logic sharedPdRefselPin,
    input wire logic externalOscInput,
    output logic refClockOutput,
    output logic refClockOutputEn_n,
    output logic divClockOutput,
    output logic divClockOutputEn_n
);
    import ods_pkg::*;

    function automatic logic addrIs(input logic [3:0] addr, input logic [3:0] target);
        addrIs = (addr == target);
    endfunction

    // ****************************************
    // Register bus
    // ****************************************
    ods_mode_t modeWord;
    logic [8:0] dividerWord;
    ods_status_t status;
    logic busReq;

    assign busReq = avs_read | avs_write;

    // One wait cycle on every access, then the answer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(busReq && avs_waitrequest);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            if (addrIs(avs_address, ADDR_MODE)) begin
                avs_readdata <= {23'h000000, modeWord};
            end else if (addrIs(avs_address, ADDR_DIV)) begin
                avs_readdata <= {23'h000000, dividerWord};
            end else if (addrIs(avs_address, ADDR_STATUS)) begin
                avs_readdata <= status;
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeWord <= MODE_RESET;
            dividerWord <= DIV_RESET;
        end else if (avs_write && !avs_waitrequest) begin
            if (addrIs(avs_address, ADDR_MODE)) begin
                if (avs_byteenable[0]) begin
                    modeWord[7:0] <= avs_writedata[7:0] & MODE_WRITE_MASK[7:0];
                end
                if (avs_byteenable[1]) begin
                    modeWord[8] <= avs_writedata[8] & MODE_WRITE_MASK[8];
                end
            end else if (addrIs(avs_address, ADDR_DIV)) begin
                if (avs_byteenable[0]) begin
                    dividerWord[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    dividerWord[8] <= avs_writedata[8];
                end
            end
        end
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] asyncIn;
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic oeSync;
    logic pinSync;
    logic extSync;

    assign asyncIn = {outputEnable, sharedPdRefselPin, externalOscInput};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    syncA[i] <= SYNC_RESET[i];
                    syncB[i] <= SYNC_RESET[i];
                end else begin
                    syncA[i] <= asyncIn[i];
                    syncB[i] <= syncA[i];
                end
            end
        end
    endgenerate

    assign oeSync = syncB[2];
    assign pinSync = syncB[1];
    assign extSync = syncB[0];

    // ****************************************
    // Internal oscillator and prescaler
    // ****************************************
    ods_pd_state_t pdState;
    logic [2:0] oscCnt;
    logic internal_reference_clock;
    logic intClkPrev;
    logic intFall;
    logic intEdge;
    logic skipPrescale;

    // Oscillator halts only in the deepest power-down state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oscCnt <= 3'h0;
        end else if (pdState != PD_REF_OFF) begin
            oscCnt <= oscCnt + 3'h1;
        end
    end

    assign skipPrescale = modeWord.prescaleBypass | modeWord.dividerBypass;
    assign internal_reference_clock = skipPrescale ? oscCnt[0] : (modeWord.prescaleHalf ? oscCnt[1] : oscCnt[2]);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intClkPrev <= 1'b0;
        end else begin
            intClkPrev <= internal_reference_clock;
        end
    end

    assign intFall = intClkPrev & ~internal_reference_clock;
    assign intEdge = intClkPrev ^ internal_reference_clock;

    // ****************************************
    // Glitch-free reference switch
    // ****************************************
    ods_sw_state_t swState;
    logic wantExt;
    logic pdReq;
    logic halfDone;
    logic mclk;
    logic mclkPrev;
    logic mclkRise;
    logic mclkFall;

    assign wantExt = modeWord.pdSelect ? modeWord.extSelect : ~pinSync;
    assign pdReq = modeWord.pdSelect & ~pinSync;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            swState <= SW_INT;
            halfDone <= 1'b0;
            mclk <= 1'b0;
        end else begin
            case (swState)
                SW_INT: begin
                    mclk <= internal_reference_clock;
                    if (wantExt && intFall) begin
                        swState <= SW_HOLD_EXT;
                        halfDone <= 1'b0;
                    end
                end
                SW_HOLD_EXT: begin
                    mclk <= 1'b0;
                    if (intEdge) begin
                        halfDone <= 1'b1;
                    end
                    if (halfDone && !extSync) begin
                        swState <= SW_EXT;
                    end
                end
                SW_EXT: begin
                    mclk <= extSync;
                    if (!wantExt && !extSync) begin
                        swState <= SW_HOLD_INT;
                    end
                end
                SW_HOLD_INT: begin
                    mclk <= 1'b0;
                    if (intFall) begin
                        swState <= SW_INT;
                    end
                end
                default: begin
                    swState <= SW_INT;
                    mclk <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mclkPrev <= 1'b0;
        end else begin
            mclkPrev <= mclk;
        end
    end

    assign mclkRise = mclk & ~mclkPrev;
    assign mclkFall = mclkPrev & ~mclk;

    // ****************************************
    // Enabling sequencer and divider
    // ****************************************
    logic oeSampled;
    logic divGate;
    logic divOut;
    logic [9:0] divCnt;
    logic [9:0] divisor;
    logic [9:0] highLen;
    logic dividerIdle;

    assign divisor = {1'b0, dividerWord} + {1'b0, DIVISOR_OFFSET};
    assign highLen = {1'b0, divisor[9:1]};

    // Sample taken on a master rise is acted on at the next one, giving
    // the one to two master period latency on enable and disable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oeSampled <= 1'b0;
        end else if (mclkRise) begin
            oeSampled <= oeSync & (pdState == PD_RUN);
        end
    end

    // Divide-by-one gate moves only while the master clock is low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            divGate <= 1'b0;
        end else if (mclkFall) begin
            divGate <= oeSampled;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            divCnt <= 10'h000;
            divOut <= 1'b0;
        end else if (mclkRise) begin
            if (oeSampled) begin
                divOut <= (divCnt < highLen);
                divCnt <= (divCnt == divisor - 10'h001) ? 10'h000 : divCnt + 10'h001;
            end else if (divOut && (divCnt < highLen)) begin
                divCnt <= divCnt + 10'h001;
            end else begin
                divCnt <= 10'h000;
                divOut <= 1'b0;
            end
        end
    end

    assign dividerIdle = !divOut && !divGate && (divCnt == 10'h000);

    // ****************************************
    // Power-down sequencer
    // ****************************************
    logic [8:0] stabCnt;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pdState <= PD_RUN;
            stabCnt <= 9'h000;
        end else begin
            case (pdState)
                PD_RUN: begin
                    if (pdReq) begin
                        pdState <= PD_OUT_OFF;
                    end
                end
                PD_OUT_OFF: begin
                    // Reference stops only while low, so no runt pulse
                    if (dividerIdle && !oeSampled && !mclk) begin
                        pdState <= PD_REF_OFF;
                    end
                end
                PD_REF_OFF: begin
                    if (!pdReq) begin
                        pdState <= PD_WAKE;
                        stabCnt <= 9'h000;
                    end
                end
                PD_WAKE: begin
                    if (mclkRise) begin
                        if (stabCnt == STAB_LAST) begin
                            pdState <= PD_RUN;
                        end else begin
                            stabCnt <= stabCnt + 9'h001;
                        end
                    end
                end
                default: begin
                    pdState <= PD_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Output pins
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            refClockOutput <= 1'b0;
            refClockOutputEn_n <= 1'b1;
        end else begin
            // Output-enable deliberately plays no part here
            refClockOutput <= mclk;
            refClockOutputEn_n <= modeWord.refOutDisable ||
                ((pdState != PD_RUN) && (pdState != PD_OUT_OFF));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            divClockOutput <= 1'b0;
            divClockOutputEn_n <= 1'b1;
        end else begin
            divClockOutput <= modeWord.dividerBypass ? (mclk & divGate) : divOut;
            divClockOutputEn_n <= !((pdState == PD_RUN) ||
                ((pdState == PD_OUT_OFF) && !dividerIdle));
        end
    end

    always_comb begin
        status = '0;
        status.swState = swState;
        status.pdState = pdState;
        status.divOut = divOut;
        status.divGate = divGate;
        status.oeSampled = oeSampled;
        status.usingExt = (swState == SW_EXT);
    end
endmodule

// *** dv/ods_osc_divider_assertions.sv ***
// Port-level checks for the oscillator divider
`timescale 1ns/100ps
module ods_osc_divider_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic outputEnable,
    input wire logic sharedPdRefselPin,
    input wire logic externalOscInput,
    input wire logic refClockOutput,
    input wire logic refClockOutputEn_n,
    input wire logic divClockOutput,
    input wire logic divClockOutputEn_n
);
    logic [2:0] offRises;
    logic [11:0] oeLowCnt;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Sync lag lets a normal rise slip past before the extra one
    always_ff @(posedge clk_sys) begin
        if (!rst_n || outputEnable) begin
            offRises <= 3'h0;
        end else if ($rose(divClockOutput) && offRises != 3'h7) begin
            offRises <= offRises + 3'h1;
        end
    end
    // Saturates past the longest finishing pulse on the internal reference
    always_ff @(posedge clk_sys) begin
        if (!rst_n || outputEnable) begin
            oeLowCnt <= 12'h000;
        end else if (oeLowCnt != 12'hFFF) begin
            oeLowCnt <= oeLowCnt + 12'h001;
        end
    end
    sequence s_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_oe_off_long;
        (!outputEnable && !divClockOutput && sharedPdRefselPin)[*8] ##1 outputEnable;
    endsequence
    a_wait_one_cycle: assert property (s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for one cycle");
    a_wait_idle_high: assert property (avs_waitrequest && !avs_read && !avs_write
        |=> avs_waitrequest) else $error("waitrequest dropped while idle");
    a_readdata_stands: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_enable_first_rise: assert property (
        s_oe_off_long |-> ##[1:40] ($rose(divClockOutput) || !outputEnable))
        else $error("no divided rise after enable");
    a_disable_extra_pulses: assert property (offRises <= 3'h3)
        else $error("too many pulses after disable");
    a_off_holds_low: assert property (oeLowCnt == 12'hFFF |-> !divClockOutput)
        else $error("divided output high while disabled");
    a_ref_drive_steady: assert property (
        (!refClockOutputEn_n && !avs_write && sharedPdRefselPin)[*8] |=> !refClockOutputEn_n)
        else $error("reference drive dropped");
    a_div_drive_steady: assert property (
        (!divClockOutputEn_n && sharedPdRefselPin)[*8] |=> !divClockOutputEn_n)
        else $error("divided drive dropped");
endmodule

// *** dv/ods_board_model.sv ***
// Board model: external reference source and divided clock monitor
`timescale 1ns/100ps
module ods_board_model (
    input wire logic clk_sys,
    input wire logic divClockOutput,
    input wire logic extHold,
    input wire logic clearStats,
    output logic externalOscInput,
    output logic [15:0] divPeriod,
    output logic [15:0] divHighMin
);
    logic [15:0] sinceRise = 16'h0000;
    logic [15:0] highLen = 16'h0000;
    logic prevDiv = 1'b0;
    logic extLevel = 1'b0;
    assign externalOscInput = extLevel;
    // Free running, unrelated in phase; a stuck-high source blocks the return
    always begin
        #23.7;
        extLevel = extHold ? 1'b1 : ~extLevel;
    end
    always @(posedge clk_sys) begin
        prevDiv <= divClockOutput;
        sinceRise <= sinceRise + 16'h0001;
        highLen <= divClockOutput ? highLen + 16'h0001 : 16'h0000;
        if (clearStats) begin
            divHighMin <= 16'hFFFF;
        end else if (prevDiv && !divClockOutput && highLen < divHighMin) begin
            divHighMin <= highLen;
        end
        if (!prevDiv && divClockOutput) begin
            divPeriod <= sinceRise;
            sinceRise <= 16'h0001;
        end
    end
endmodule

// *** dv/ods_osc_divider_tb_top.sv ***
// Testbench for the oscillator divider and enabling sequencer
`timescale 1ns/100ps
module ods_osc_divider_tb_top;
    import ods_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic outputEnable = 1'b1;
    logic sharedPdRefselPin = 1'b1;
    logic externalOscInput;
    logic refClockOutput;
    logic refClockOutputEn_n;
    logic divClockOutput;
    logic divClockOutputEn_n;
    logic extHold = 1'b0;
    logic clearStats = 1'b0;
    logic [15:0] divPeriod;
    logic [15:0] divHighMin;
    logic [31:0] rd;
    logic [8:0] dv;
    logic refPrev;
    int m;
    int n_fail = 0;
    int comparisons = 0;
    // Prescale bypass, half, quarter, then divide-by-one
    logic [8:0] modeTab [4] = '{9'h014, 9'h018, 9'h010, 9'h016};
    int mperTab [4] = '{2, 4, 8, 2};
    always #4 clk_sys = ~clk_sys;
    ods_osc_divider u_ods_osc_divider (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .outputEnable(outputEnable),
        .sharedPdRefselPin(sharedPdRefselPin), .externalOscInput(externalOscInput),
        .refClockOutput(refClockOutput), .refClockOutputEn_n(refClockOutputEn_n),
        .divClockOutput(divClockOutput), .divClockOutputEn_n(divClockOutputEn_n));
    ods_board_model u_ods_board_model (
        .clk_sys(clk_sys), .divClockOutput(divClockOutput), .extHold(extHold),
        .clearStats(clearStats), .externalOscInput(externalOscInput),
        .divPeriod(divPeriod), .divHighMin(divHighMin));
    function automatic int exp_period(input logic [8:0] d, input int k);
        return (k == 3) ? 2 : (int'(d) + 2) * mperTab[k];
    endfunction
    function automatic int exp_high(input logic [8:0] d, input int k);
        return (k == 3) ? 1 : ((int'(d) + 2) / 2) * mperTab[k];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk("bus answer", {31'h0, avs_waitrequest}, 32'h0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    initial begin
        tick(20000);
        n_fail++;
        stop_test();
    end
    initial begin
        void'($urandom(71804));
        tick(3);
        chk("reset drives", {30'h0, refClockOutputEn_n, divClockOutputEn_n}, 32'h3);
        chk("reset wait", {31'h0, avs_waitrequest}, 32'h1);
        rst_n <= 1'b1;
        bus(1'b0, ADDR_MODE, 32'h0);
        chk("mode reset", rd, {23'h0, MODE_RESET});
        bus(1'b0, ADDR_DIV, 32'h0);
        chk("divider reset", rd, {23'h0, DIV_RESET});
        chk("ref drive off", {31'h0, refClockOutputEn_n}, 32'h1);
        bus(1'b1, 4'hC, 32'h1FF);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped read", rd, 32'h0);
        bus(1'b1, ADDR_MODE, 32'h1D4);
        bus(1'b0, ADDR_MODE, 32'h0);
        chk("mode masked", rd, 32'h014);
        tick(20);
        chk("ref drive on", {31'h0, refClockOutputEn_n}, 32'h0);
        refPrev = refClockOutput;
        tick(1);
        chk("ref toggles", {31'h0, refClockOutput}, {31'h0, ~refPrev});
        for (int i = 0; i < 8; i++) begin
            m = i % 4;
            dv = (i < 4) ? 9'(i) : 9'($urandom_range(5));
            bus(1'b1, ADDR_DIV, {23'h0, dv});
            bus(1'b1, ADDR_MODE, {23'h0, modeTab[m]});
            tick(100);
            clearStats <= 1'b1;
            tick(1);
            clearStats <= 1'b0;
            outputEnable <= 1'b0;
            tick($urandom_range(80, 20));
            // Reference keeps toggling every half master period while disabled
            refPrev = refClockOutput;
            tick(mperTab[m] / 2);
            chk("ref ignores enable", {31'h0, refClockOutput}, {31'h0, ~refPrev});
            outputEnable <= 1'b1;
            tick(200);
            chk("div period", {16'h0, divPeriod}, 32'(exp_period(dv, m)));
            chk("div high min", {16'h0, divHighMin}, 32'(exp_high(dv, m)));
        end
        outputEnable <= 1'b0;
        tick(4200);
        chk("div held low", {31'h0, divClockOutput}, 32'h0);
        chk("div still driven", {31'h0, divClockOutputEn_n}, 32'h0);
        outputEnable <= 1'b1;
        bus(1'b1, ADDR_MODE, 32'h004);
        sharedPdRefselPin <= 1'b0;
        tick(100);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("ext in use", {29'h0, rd[7], rd[1:0]}, {29'h0, 1'b1, SW_EXT});
        extHold <= 1'b1;
        // Let the stuck-high level reach the synchroniser before asking to return
        tick(10);
        sharedPdRefselPin <= 1'b1;
        tick(100);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("switch stalls", {31'h0, rd[1:0] === SW_INT}, 32'h0);
        extHold <= 1'b0;
        tick(100);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("int in use", {29'h0, rd[7], rd[1:0]}, {29'h0, 1'b0, SW_INT});
        bus(1'b1, ADDR_MODE, 32'h014);
        sharedPdRefselPin <= 1'b0;
        tick(200);
        chk("pd drives", {30'h0, refClockOutputEn_n, divClockOutputEn_n}, 32'h3);
        sharedPdRefselPin <= 1'b1;
        tick(700);
        chk("wake drives", {30'h0, refClockOutputEn_n, divClockOutputEn_n}, 32'h0);
        stop_test();
    end
endmodule
bind ods_osc_divider ods_osc_divider_assertions u_ods_osc_divider_assertions (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .outputEnable(outputEnable), .sharedPdRefselPin(sharedPdRefselPin),
    .externalOscInput(externalOscInput), .refClockOutput(refClockOutput),
    .refClockOutputEn_n(refClockOutputEn_n), .divClockOutput(divClockOutput),
    .divClockOutputEn_n(divClockOutputEn_n));
